/* hdl/cdc_counter_top.sv */
`default_nettype none

module cdc_counter_top
    import cdc_pkg::*;
#(
    parameter int unsigned TICK_CYC = cdc_pkg::TICK_CYCLES,
    parameter int unsigned SLEEP_CYC = cdc_pkg::SLEEP_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic signed [cdc_pkg::SENSE_W-1:0] sense_battery_side,
    input wire logic signed [cdc_pkg::SENSE_W-1:0] sense_pack_side,
    input wire logic [2:0] temp_code,
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_n,
    output logic wake_o,
    output logic wake_oe_n,
    output logic mode_sleep,
    input wire logic reg_req,
    input wire logic reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_ack
);
    import cdc_pkg::*;

    cdc_mode_t mode_ff;
    cdc_mode_t nxt_mode;
    logic [31:0] tb_cnt_ff;
    logic [31:0] slp_cnt_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [EFF_W-1:0] frac_ff;
    logic [EFF_W-1:0] nxt_frac;
    logic [CNT_W-1:0] cnt_ff [NUM_CNT];
    logic [NUM_CNT-1:0] inc;
    logic [NUM_CNT-1:0] wrap;
    logic [4:0] clr_ff;
    logic dslow_ff;
    logic cslow_ff;
    logic [1:0] ctrl_ff;
    logic [2:0] wake_code_ff;
    logic [7:0] ofr_ff;
    logic wake_oe_n_ff;
    logic drive_lo_ff;
    logic sleep_out_ff;
    logic rd1_ff;
    logic user1_ff;
    logic [7:0] own1_ff;
    logic [7:0] rdata_ff;
    logic ack_ff;

    logic running;
    logic tick;
    logic signed [EFF_W-1:0] eff_v;
    logic [EFF_W-1:0] mag;
    logic is_dis;
    logic is_chg;
    logic above_thr;
    logic quiet;
    logic acc_inc;
    logic slow_due;
    logic [PRE_W-1:0] self_mask;
    logic self_due;
    logic acc_ok;
    logic wr_ok;
    logic wr_mode;
    logic wr_clr;
    logic wr_ofr;
    logic sel_cnt;
    logic [2:0] cnt_idx;
    logic [CNT_W-1:0] cnt_sel;
    logic [7:0] mode_rd;
    logic [7:0] clr_rd;
    logic [7:0] own_byte;

    cdc_mem_if mem_bus ();

    cdc_user_mem u_mem (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .port(mem_bus.mem)
    );

    assign running = (mode_ff == CDC_RUN);
    assign tick = running && (tb_cnt_ff == TICK_CYC - 1);

    assign eff_v = EFF_W'(sense_battery_side) - EFF_W'(sense_pack_side)
        + EFF_W'($signed(ofr_ff));
    assign mag = eff_v[EFF_W-1] ? EFF_W'(-eff_v) : EFF_W'(eff_v);
    assign is_dis = eff_v[EFF_W-1];
    assign is_chg = !eff_v[EFF_W-1] && (eff_v != '0);

    assign above_thr = (wake_code_ff != 3'h0)
        && (mag > EFF_W'(WAKE_THR_UV[wake_code_ff]));
    assign quiet = !line_i && !above_thr;

    // drain one quantum per cycle; several per tick is fine
    assign acc_inc = running && (frac_ff >= COUNT_QUANTUM);
    assign nxt_frac = frac_ff - (acc_inc ? COUNT_QUANTUM : '0)
        + (tick ? mag : '0);

    // slow rate is every 256th tick, 225 s
    assign slow_due = (pre_ff[7:0] == SLOW_MASK);

    // period 256 ticks at code 7 up to 32768 at code 0
    assign self_mask = PRE_W'({SELF_BASE_MASK, 7'h7F} >> temp_code)
        | SELF_BASE_MASK;
    assign self_due = ((pre_ff & self_mask) == self_mask);

    assign inc[IDX_DIS] = acc_inc && is_dis;
    assign inc[IDX_CHG] = acc_inc && !is_dis;
    assign inc[IDX_SELF] = tick && self_due;
    assign inc[IDX_DTIM] = tick && is_dis && (!dslow_ff || slow_due);
    assign inc[IDX_CTIM] = tick && is_chg && (!cslow_ff || slow_due);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++)
        begin : g_cnt
            assign wrap[gi] = inc[gi] && (cnt_ff[gi] == CNT_MAX);

            always_ff @(posedge sys_clk)
            begin
                if (!nrst || clr_ff[gi])
                    cnt_ff[gi] <= CNT_RESET;
                else if (inc[gi])
                    cnt_ff[gi] <= cnt_ff[gi] + 16'h0001;
            end
        end
    endgenerate

    assign acc_ok = reg_req && running;
    assign wr_ok = acc_ok && reg_wr;
    assign wr_mode = wr_ok && (reg_addr == ADDR_MODE);
    assign wr_clr = wr_ok && (reg_addr == ADDR_TEMP_CLR);
    assign wr_ofr = wr_ok && (reg_addr == ADDR_OFFSET);

    // low 115 bytes user memory, top 13 bytes own registers
    assign mem_bus.we = wr_ok;
    assign mem_bus.addr = reg_addr;
    assign mem_bus.wdata = reg_wdata;

    assign sel_cnt = (reg_addr >= ADDR_CNT_BASE);
    assign cnt_idx = 3'((ADDR_CNT_TOP - reg_addr) >> 1);
    assign cnt_sel = (cnt_idx < 3'(NUM_CNT)) ? cnt_ff[cnt_idx] : CNT_RESET;
    assign mode_rd = {ctrl_ff, cslow_ff, dslow_ff, wake_code_ff, 1'b0};
    assign clr_rd = {temp_code, clr_ff};
    assign own_byte = sel_cnt ? (reg_addr[0] ? cnt_sel[15:8] : cnt_sel[7:0])
        : (reg_addr == ADDR_MODE) ? mode_rd
        : (reg_addr == ADDR_TEMP_CLR) ? clr_rd
        : ofr_ff;

    // sleep entry after quiet over 10 s, exit on line high
    assign nxt_mode = running
        ? ((quiet && slp_cnt_ff == SLEEP_CYC) ? CDC_SLEEP : CDC_RUN)
        : (line_i ? CDC_RUN : CDC_SLEEP);

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            mode_ff <= CDC_RUN;
            slp_cnt_ff <= 32'h0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            slp_cnt_ff <= (running && quiet) ? slp_cnt_ff + 32'h1 : 32'h0;
        end
    end

    // timebase stops in sleep so a fresh tick period follows wake-up
    always_ff @(posedge sys_clk)
    begin
        if (!nrst || !running || tick)
            tb_cnt_ff <= 32'h0;
        else
            tb_cnt_ff <= tb_cnt_ff + 32'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            pre_ff <= '0;
            frac_ff <= '0;
        end
        else
        begin
            pre_ff <= tick ? pre_ff + PRE_W'(1) : pre_ff;
            frac_ff <= running ? nxt_frac : frac_ff;
        end
    end

    // sticky until timer cleared; a wrap beats a clear
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            dslow_ff <= 1'b0;
            cslow_ff <= 1'b0;
        end
        else
        begin
            dslow_ff <= wrap[IDX_DTIM] || (dslow_ff && !clr_ff[IDX_DTIM]);
            cslow_ff <= wrap[IDX_CTIM] || (cslow_ff && !clr_ff[IDX_CTIM]);
        end
    end

    // clear bits live one cycle, then drop by themselves
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            clr_ff <= CLR_RESET;
        else
            clr_ff <= wr_clr ? reg_wdata[4:0] : CLR_RESET;
    end

    // calibration itself is not modelled; its control bits are plain storage
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            ctrl_ff <= MODE_CTRL_RESET;
            wake_code_ff <= WAKE_CODE_RESET;
            ofr_ff <= OFFSET_RESET;
        end
        else
        begin
            if (wr_mode)
            begin
                ctrl_ff <= reg_wdata[7:MODE_CTRL_LSB];
                wake_code_ff <= reg_wdata[MODE_WAKE_LSB+:3];
            end
            if (wr_ofr)
                ofr_ff <= reg_wdata;
        end
    end

    // two stage read so every answer leaves from a flop
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rd1_ff <= 1'b0;
            user1_ff <= 1'b0;
            own1_ff <= 8'h00;
            rdata_ff <= 8'h00;
            ack_ff <= 1'b0;
        end
        else
        begin
            rd1_ff <= acc_ok;
            user1_ff <= (reg_addr <= ADDR_USER_TOP);
            own1_ff <= own_byte;
            rdata_ff <= rd1_ff ? (user1_ff ? mem_bus.rdata : own1_ff)
                : rdata_ff;
            ack_ff <= rd1_ff;
        end
    end

    // open drain wake, low only above threshold while awake
    // wake is only ever pulled low, never driven high; line is never driven at all
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            wake_oe_n_ff <= 1'b1;
            drive_lo_ff <= 1'b0;
            sleep_out_ff <= 1'b0;
        end
        else
        begin
            wake_oe_n_ff <= !(running && above_thr);
            drive_lo_ff <= 1'b0;
            sleep_out_ff <= (nxt_mode == CDC_SLEEP);
        end
    end

    assign wake_o = drive_lo_ff;
    assign wake_oe_n = wake_oe_n_ff;
    assign line_o = drive_lo_ff;
    // serial framing is outside this block, so the line is left released
    assign line_oe_n = 1'b1;
    assign mode_sleep = sleep_out_ff;
    assign reg_rdata = rdata_ff;
    assign reg_ack = ack_ff;

    a_wake_low_above:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        (running && above_thr) |=> !wake_oe_n)
    else $error("wake not pulled low above threshold");

    a_wake_free_sleep:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        (!running || !above_thr) |=> wake_oe_n)
    else $error("wake pulled low while quiet or asleep");

    a_sleep_entry:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        (running && quiet && slp_cnt_ff == SLEEP_CYC) |=> mode_sleep)
    else $error("sleep not entered after quiet period");

    a_sleep_stays:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        (!running && !line_i) |=> (!running && $stable(cnt_ff[IDX_SELF])))
    else $error("sleep left or counting while line low");

    a_sleep_exit:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        (!running && line_i) |=> running)
    else $error("sleep not left on line high");

    a_dtimer_step:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        (tick && is_dis && !dslow_ff && clr_ff == 5'h00
            && cnt_ff[IDX_DTIM] != CNT_MAX)
        |=> cnt_ff[IDX_DTIM] == $past(cnt_ff[IDX_DTIM]) + 16'h0001)
    else $error("discharge timer missed a tick");

    a_wrap_sets_slow:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        wrap[IDX_CTIM] |=> (cslow_ff && cnt_ff[IDX_CTIM] == CNT_RESET))
    else $error("charge timer wrap lost");

    a_slow_sticky:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        (cslow_ff && !clr_ff[IDX_CTIM]) |=> cslow_ff)
    else $error("slow flag dropped without clear");

    a_slow_rate:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        (cslow_ff && tick && pre_ff[7:0] != SLOW_MASK && clr_ff == 5'h00)
        |=> $stable(cnt_ff[IDX_CTIM]))
    else $error("slow charge timer counted early");

    a_one_pair:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        !(inc[IDX_DTIM] && inc[IDX_CTIM]) && !(inc[IDX_DIS] && inc[IDX_CHG]))
    else $error("both pairs active together");

    a_accum_step:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        (acc_inc && is_dis && !clr_ff[IDX_DIS]
            && cnt_ff[IDX_DIS] != CNT_MAX)
        |=> cnt_ff[IDX_DIS] == $past(cnt_ff[IDX_DIS]) + 16'h0001)
    else $error("discharge accumulator missed a count");

    a_clear_zeroes:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_clr ##1 clr_ff[IDX_CHG] |=> (cnt_ff[IDX_CHG] == CNT_RESET))
    else $error("charge accumulator not cleared");

    a_sleep_refused:
    assert property (@(posedge sys_clk) disable iff (!nrst)
        (!running && reg_req) |-> ##2 !reg_ack)
    else $error("access answered in sleep");
endmodule

`default_nettype wire

/* hdl/cdc_pkg.sv */
// Overview of operation
// - discharge: discharge accumulator counts once per 12.5 uVh of sense
// - discharging: discharge timer counts once per 0.8789 s, 4096 per hour
// - charging: charge accumulator counts once per 12.5 uVh of sense signal
// - charging: charge timer counts once per 0.8789 s by default
// - sense sign selects one pair only: discharge pair or charge pair
// - timers are 16 bits, wrap past FFFF and set their slow flag
// - after a wrap a timer counts at 1/256 rate, 16 per hour
// - with slow flag set the timer counts once per 225 s
// - line high and sense above threshold: self-discharge and one counter pair run, wake driven low
// - register memory is reachable by the host only while operational
// - quiet sense and line low over 10 s: sleep until line high
// - wake driven low only above threshold, released otherwise and in sleep
// - threshold compares sense difference plus stored offset
// - self-discharge counts hourly at 25 C, doubling per 10 C up to 60 C
// - self-discharge halves per 10 C below 25 C; multipliers 1/8 to 16
// - single wire line is open drain, only pulled low by the device; here line_oe_n is tied high, so it is never pulled low
// - 128 byte register memory; top 13 bytes are counters and status
// - temperature reported as 3 bit band code, scales self-discharge rate
// - clear bit written 1 zeroes its counter, then returns to 0 itself
`default_nettype none

package cdc_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_NS = 878900000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam longint unsigned SLEEP_MS = 10000;
    localparam longint unsigned SLEEP_CYCLES_L =
        (SLEEP_MS * 64'd1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLEEP_CYCLES = int'(SLEEP_CYCLES_L);

    localparam int SENSE_W = 19;
    localparam int EFF_W = 21;
    localparam int CNT_W = 16;
    localparam int NUM_CNT = 5;
    localparam int PRE_W = 15;

    // one count = 12.5 uV over one hour of 4096 ticks, in uV-ticks
    localparam logic [EFF_W-1:0] COUNT_QUANTUM = 21'h0C800;
    localparam logic [7:0] SLOW_MASK = 8'hFF;
    localparam logic [PRE_W-1:0] SELF_BASE_MASK = 15'h00FF;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

    localparam logic [6:0] ADDR_USER_TOP = 7'h72;
    localparam logic [6:0] ADDR_OFFSET = 7'h73;
    localparam logic [6:0] ADDR_TEMP_CLR = 7'h74;
    localparam logic [6:0] ADDR_MODE = 7'h75;
    localparam logic [6:0] ADDR_CNT_BASE = 7'h76;
    localparam logic [6:0] ADDR_CNT_TOP = 7'h7F;
    localparam int USER_BYTES = 115;

    localparam int IDX_DIS = 0;
    localparam int IDX_CHG = 1;
    localparam int IDX_SELF = 2;
    localparam int IDX_DTIM = 3;
    localparam int IDX_CTIM = 4;

    localparam int MODE_CTRL_LSB = 6;
    localparam int MODE_CSLOW_BIT = 5;
    localparam int MODE_DSLOW_BIT = 4;
    localparam int MODE_WAKE_LSB = 1;
    localparam int TEMP_LSB = 5;
    localparam logic [1:0] MODE_CTRL_RESET = 2'h0;
    localparam logic [2:0] WAKE_CODE_RESET = 3'h7;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [4:0] CLR_RESET = 5'h00;

    // thresholds in uV, index is the wake code; code 0 is unused
    localparam logic [11:0] WAKE_THR_UV [8] = '{
        12'h000, 12'hF00, 12'h780, 12'h500,
        12'h3C0, 12'h300, 12'h280, 12'h225
    };

    typedef enum logic {
        CDC_RUN = 1'b0,
        CDC_SLEEP = 1'b1
    } cdc_mode_t;

endpackage

`default_nettype wire

/* hdl/cdc_mem_if.sv */
`default_nettype none

interface cdc_mem_if;
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

/* hdl/cdc_user_mem.sv */
`default_nettype none

module cdc_user_mem
    import cdc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    cdc_mem_if.mem port
);
    // plain storage, not reset: contents survive only as long as power does
    logic [7:0] mem_q [USER_BYTES];
    logic [7:0] rdata_ff;
    logic in_range;

    assign in_range = (port.addr <= ADDR_USER_TOP);
    assign port.rdata = rdata_ff;

    always_ff @(posedge sys_clk)
    begin
        if (port.we && in_range)
        begin
            mem_q[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rdata_ff <= 8'h00;
        end
        else
        begin
            rdata_ff <= in_range ? mem_q[port.addr] : 8'h00;
        end
    end
endmodule

`default_nettype wire

/* test/cdc_host_model.sv */
`default_nettype none

module cdc_host_model
(
    input wire logic sys_clk,
    input wire logic line_o,
    input wire logic line_oe_n,
    output var logic line_i,
    output var logic reg_req,
    output var logic reg_wr,
    output var logic [6:0] reg_addr,
    output var logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pull_low = 1'b0;
    // open drain wire
    // pack pull-up: a released line reads high, never stale
    assign line_i = !pull_low && (line_oe_n || line_o);
    initial
    begin
        reg_req = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    task automatic access(input logic wr, input logic [6:0] a,
        input logic [7:0] d, output logic [7:0] q, output bit ok);
        int n;
        ok = 1'b0;
        q = 8'h00;
        @(posedge sys_clk);
        #1;
        reg_req = 1'b1;
        reg_wr = wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1;
        reg_req = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        // bounded: a refused request just never answers
        for (n = 0; n < 4 && !ok; n++)
        begin
            @(posedge sys_clk);
            if (reg_ack === 1'b1)
            begin
                q = reg_rdata;
                ok = 1'b1;
            end
        end
        // hand back off the edge so callers never race the design
        #1;
    endtask
endmodule

`default_nettype wire

/* test/testbench.sv */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import cdc_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic signed [SENSE_W-1:0] sb = '0;
    logic signed [SENSE_W-1:0] sp = '0;
    logic [2:0] temp = 3'h7;
    logic line_i, line_o, line_oe_n, wake_o, wake_oe_n, mode_sleep;
    logic reg_req, reg_wr, reg_ack;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, q;
    logic [15:0] v0, v1;
    logic [18:0] thr [8] = '{19'h0, 19'hF00, 19'h780, 19'h500,
        19'h3C0, 19'h300, 19'h280, 19'h225};
    int err_count = 0;
    int num_checks = 0;
    bit ok;

    always #5 sys_clk = ~sys_clk;

    cdc_counter_top #(.TICK_CYC(1), .SLEEP_CYC(20)) DUT (
        .sys_clk(sys_clk), .nrst(nrst), .sense_battery_side(sb),
        .sense_pack_side(sp), .temp_code(temp), .line_i(line_i),
        .line_o(line_o), .line_oe_n(line_oe_n), .wake_o(wake_o),
        .wake_oe_n(wake_oe_n), .mode_sleep(mode_sleep),
        .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));

    cdc_host_model host (
        .sys_clk(sys_clk), .line_o(line_o), .line_oe_n(line_oe_n),
        .line_i(line_i), .reg_req(reg_req), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack));

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [15:0] got,
        input logic [15:0] lo, input logic [15:0] hi);
        logic in;
        in = (got >= lo) && (got <= hi);
        num_checks++;
        if (in !== 1'b1)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic go(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.access(1'b1, a, d, x, ok);
        chk({15'h0, ok}, 16'h1);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        host.access(1'b0, a, 8'h00, q, ok);
        chk({15'h0, ok}, 16'h1);
        chk({8'h0, q}, {8'h0, e});
    endtask

    task automatic rd16(input logic [6:0] a, output logic [15:0] v);
        host.access(1'b0, 7'(a + 7'h01), 8'h00, v[15:8], ok);
        host.access(1'b0, a, 8'h00, v[7:0], ok);
    endtask

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        go(8);
        nrst = 1'b1;
        rdc(7'h75, 8'h0E);
        rdc(7'h73, 8'h00);
        rdc(7'h74, 8'hE0);
        for (int i = 0; i < 5; i++)
        begin
            rd16(7'(7'h76 + 2 * i), v0);
            chk(v0, 16'h0000);
        end
        chk({15'h0, wake_oe_n}, 16'h1);
        chk({15'h0, line_oe_n}, 16'h1);
        chk({14'h0, wake_o, line_o}, 16'h0);
        wr(7'h00, 8'hA5);
        wr(7'h72, 8'h5A);
        wr(7'h7F, 8'h12);
        rdc(7'h00, 8'hA5);
        rdc(7'h72, 8'h5A);
        rdc(7'h7F, 8'h00);
        // discharge then charge, each at one count per tick
        sp = 19'sh0C800;
        go(300);
        chk({15'h0, wake_oe_n}, 16'h0);
        // read mid-discharge: a zero input hands the leftover to charge
        rd16(7'h7C, v0);
        chk(v0, 16'h0000);
        sp = '0;
        go(4);
        rd16(7'h7E, v0);
        chk_rng(v0, 16'h130, 16'h136);
        rd16(7'h78, v0);
        chk_rng(v0, 16'h130, 16'h136);
        sb = 19'sh0C800;
        go(300);
        sb = '0;
        go(4);
        rd16(7'h7C, v0);
        chk_rng(v0, 16'h128, 16'h12E);
        rd16(7'h76, v0);
        chk_rng(v0, 16'h128, 16'h12E);
        wr(7'h74, 8'h1B);
        rdc(7'h74, 8'hE0);
        for (int i = 0; i < 4; i++)
        begin
            rd16(i < 2 ? 7'(7'h76 + 2 * i) : 7'(7'h78 + 2 * i), v0);
            chk(v0, 16'h0000);
        end
        // self-discharge over 4096 ticks at two bands
        for (int t = 7; t > 5; t--)
        begin
            temp = 3'(t);
            wr(7'h74, 8'h04);
            go(4096);
            rd16(7'h7A, v0);
            chk_rng(v0, 16'(32 >> (8 - t)) - 16'h1,
                16'(32 >> (8 - t)) + 16'h1);
        end
        wr(7'h75, 8'hFF);
        rdc(7'h75, 8'hCE);
        for (int c = 1; c < 8; c++)
        begin
            wr(7'h75, {4'h0, 3'(c), 1'b0});
            sb = thr[c] + 19'h1;
            go(3);
            chk({15'h0, wake_oe_n}, 16'h0);
            sb = thr[c];
            go(3);
            chk({15'h0, wake_oe_n}, 16'h1);
        end
        wr(7'h73, 8'h64);
        sb = 19'sh1C2;
        go(3);
        chk({15'h0, wake_oe_n}, 16'h0);
        wr(7'h73, 8'h9C);
        sb = 19'sh288;
        go(3);
        chk({15'h0, wake_oe_n}, 16'h1);
        wr(7'h73, 8'h00);
        wr(7'h75, 8'h00);
        sb = 19'sh1388;
        go(3);
        chk({15'h0, wake_oe_n}, 16'h1);
        wr(7'h75, 8'h0E);
        sb = '0;
        // quiet line low: sleep only after the hold time
        host.pull_low = 1'b1;
        go(10);
        chk({15'h0, mode_sleep}, 16'h0);
        go(20);
        chk({15'h0, mode_sleep}, 16'h1);
        host.access(1'b0, 7'h75, 8'h00, q, ok);
        chk({15'h0, ok}, 16'h0);
        sp = 19'sh0C800;
        go(50);
        chk({15'h0, wake_oe_n}, 16'h1);
        sp = '0;
        host.pull_low = 1'b0;
        go(3);
        chk({15'h0, mode_sleep}, 16'h0);
        rd16(7'h78, v0);
        chk(v0, 16'h0000);
        // charge timer wrap and slow rate
        wr(7'h74, 8'h10);
        sb = 19'sh0C800;
        go(65545);
        rdc(7'h75, 8'h2E);
        rd16(7'h76, v0);
        go(1024);
        rd16(7'h76, v1);
        chk_rng(v1 - v0, 16'h3, 16'h5);
        sb = '0;
        go(2);
        wr(7'h74, 8'h10);
        rdc(7'h75, 8'h0E);
        rd16(7'h76, v0);
        chk(v0, 16'h0000);
        tally_and_finish();
    end
endmodule

`default_nettype wire
